// file: design/standby_well_pkg.sv
package standby_well_pkg;
  // --------
  // Register map of the battery and standby register set
  // --------
  localparam logic [7:0] OFS_WAKE_EN_SEVEN = 8'h10;
  localparam logic [7:0] OFS_PWR_RECOVERY = 8'h49;
  localparam logic [7:0] OFS_SUPPLY_ON = 8'h4A;
  localparam logic [7:0] OFS_SUPPLY_PREV = 8'h53;
  localparam logic [7:0] OFS_DOUBLE_CLICK = 8'h5B;
  localparam logic [7:0] OFS_MAKE_ONE = 8'h5F;
  localparam logic [7:0] OFS_MAKE_TWO = 8'h60;
  localparam logic [7:0] OFS_BREAK_ONE = 8'h61;
  localparam logic [7:0] OFS_BREAK_TWO = 8'h62;
  localparam logic [7:0] OFS_BREAK_THREE = 8'h63;
  localparam logic [7:0] OFS_PWR_BTN_KEY = 8'h64;
  localparam logic [7:0] OFS_SLOW_CLK_STATUS = 8'hF0;
  // Number of battery-backed registers and their storage order.
  localparam int BAT_REG_COUNT = 11;
  localparam logic [7:0] BAT_OFFSETS [BAT_REG_COUNT] = '{
    OFS_WAKE_EN_SEVEN, OFS_PWR_RECOVERY, OFS_SUPPLY_ON, OFS_SUPPLY_PREV,
    OFS_DOUBLE_CLICK, OFS_MAKE_ONE, OFS_MAKE_TWO, OFS_BREAK_ONE,
    OFS_BREAK_TWO, OFS_BREAK_THREE, OFS_PWR_BTN_KEY};
  localparam int IDX_PWR_RECOVERY = 1;
  localparam int IDX_SUPPLY_ON = 2;
  localparam int IDX_SUPPLY_PREV = 3;
  // --------
  // Field positions and reset values
  // --------
  localparam int BIT_CLK_ABSENT = 0;
  localparam int BIT_RECOVERY_EN = 0;
  localparam int BIT_SUPPLY_ON = 0;
  localparam int BIT_PREV_ON = 0;
  localparam logic [7:0] BAT_REG_RESET = 8'h00;
  localparam logic [7:0] SLOW_STATUS_RESET = 8'h00;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;
  // --------
  // Wake pin positions inside the wake pin vector
  // --------
  localparam int WAKE_PIN_COUNT = 15;
  localparam int NON_WAKE_COUNT = 3;
  localparam int PIN_MOUSE_DATA = 3;
  localparam int PIN_SECOND_REVERT = 4;
  localparam int PIN_LED_ONE = 13;
  localparam int PIN_LED_TWO = 14;
  // --------
  // Timing
  // --------
  localparam int REF_CLK_HZ = 100_000_000;
  localparam int SLOW_CLK_HZ = 32_768;
  localparam int SLOW_HALF_CYCLES = REF_CLK_HZ / (2 * SLOW_CLK_HZ);
  // --------
  // Power recovery states
  // --------
  typedef enum logic [1:0] {
    REC_IDLE = 2'b00,
    REC_ON = 2'b01,
    REC_LOST = 2'b10,
    REC_RESTORE = 2'b11
  } recovery_state_t;
endpackage : standby_well_pkg

// file: design/slow_clk_if.sv
`timescale 1ns/100ps
// Carries the slow clock request and result between the top and selector.
interface slow_clk_if;
  logic sel_internal; // High selects the derived clock.
  logic ext_level; // Level of the external slow clock pin.
  logic out_level; // Glitch-free selected slow clock level.
  logic tick; // One-cycle pulse on each rising slow edge.
  logic active_internal; // Source that the output follows now.
  modport selector (
    input sel_internal,
    input ext_level,
    output out_level,
    output tick,
    output active_internal
  );
  modport user (
    output sel_internal,
    output ext_level,
    input out_level,
    input tick,
    input active_internal
  );
endinterface : slow_clk_if

// file: design/slow_clock_select.sv
`timescale 1ns/100ps
module slow_clock_select
  import standby_well_pkg::*;
#(
  parameter int HALF_CYCLES = SLOW_HALF_CYCLES
) (
  // Clock, reset and enable
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Request and result
  slow_clk_if.selector sc
);
  // --------
  // Internal slow clock divider
  // --------
  logic [15:0] div_count; // Half-period counter.
  logic int_level; // Derived slow clock level.
  logic active_sel; // Source currently followed.
  logic out_level; // Registered output level.

  // The derived clock toggles every half period of the slow rate.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      div_count <= 16'h0000;
      int_level <= 1'b0;
    end else if (ce_i) begin
      if (div_count == 16'(HALF_CYCLES - 1)) begin
        div_count <= 16'h0000;
        int_level <= ~int_level;
      end else begin
        div_count <= div_count + 16'h0001;
      end
    end
  end

  // --------
  // Glitch-free switch
  // --------
  // The source changes only while the output and both sources are low,
  // so neither a cut old phase nor a short new one reaches the users.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      active_sel <= 1'b0;
    end else if (ce_i) begin
      if (sc.sel_internal != active_sel && !out_level &&
          !int_level && !sc.ext_level) begin
        active_sel <= sc.sel_internal;
      end
    end
  end

  // The output follows the active source one cycle late.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      out_level <= 1'b0;
    end else if (ce_i) begin
      out_level <= active_sel ? int_level : sc.ext_level;
    end
  end

  assign sc.out_level = out_level;
  assign sc.active_internal = active_sel;
  // Rising edge of the selected clock, used as a slow tick.
  assign sc.tick = ce_i & ~out_level & (active_sel ? int_level : sc.ext_level);
endmodule : slow_clock_select

// file: design/standby_well_wake_control.sv
`timescale 1ns/100ps
// Summary of operation
// - Standby reset initializes infrared and wake logic
// - Standby only: enabled wake events drive output
// - No main supply: wake pins input only, except LED pins
// - Listed pins wake; only LED pins drive
// - Mouse pins revert to plain non-inverting input
// - Three non-wake pins never wake
// - LED pins driven without main supply
// - Runtime blocks stay active on standby
// - Recovery logic restores power after failure
// - Battery registers keep contents across standby loss
// - Previous state, click, scan code registers kept
// - Slow clock drives watchdog, LED, recovery, key
// - Clock-absent flag at bit 0, index F0
// - Flag zero means external clock present
// - Slow status cleared by standby reset
// - Flag selects external or derived slow clock
// - No external clock: slow functions need main
// - Every enabled wake event pulls wake output low
// - Main-supply logic enabled only while present
module standby_well_wake_control
  import standby_well_pkg::*;
#(
  parameter int WAKE_PINS = WAKE_PIN_COUNT,
  parameter int NON_WAKE_PINS = NON_WAKE_COUNT,
  parameter int HALF_CYCLES = SLOW_HALF_CYCLES
) (
  // Clock, reset and enable
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic bat_por_i,
  input wire logic ce_i,
  // Supply indication
  input wire logic vcc_present_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // Wake pins
  input wire logic [WAKE_PINS-1:0] wake_pin_i,
  input wire logic [WAKE_PINS-1:0] wake_pin_alt_i,
  input wire logic [WAKE_PINS-1:0] wake_pin_invert_i,
  input wire logic [WAKE_PINS-1:0] wake_pin_gpio_out_i,
  input wire logic [WAKE_PINS-1:0] wake_pin_gpio_oe_i,
  input wire logic [WAKE_PINS-1:0] wake_pin_alt_out_i,
  input wire logic [WAKE_PINS-1:0] wake_pin_alt_oe_i,
  input wire logic [WAKE_PINS-1:0] wake_pin_enable_i,
  input wire logic [WAKE_PINS-1:0] wake_status_clear_i,
  output logic [WAKE_PINS-1:0] wake_pin_o,
  output logic [WAKE_PINS-1:0] wake_pin_oe_o,
  output logic [WAKE_PINS-1:0] wake_pin_data_o,
  output logic [WAKE_PINS-1:0] wake_status_o,
  // Non-wake pins
  input wire logic [NON_WAKE_PINS-1:0] non_wake_out_i,
  input wire logic [NON_WAKE_PINS-1:0] non_wake_oe_i,
  output logic [NON_WAKE_PINS-1:0] non_wake_pin_o,
  output logic [NON_WAKE_PINS-1:0] non_wake_pin_oe_o,
  // Other wake sources and the wake output
  input wire logic block_event_i,
  output logic wake_event_out_n_o,
  output logic wake_event_out_oe_o,
  // Slow clock
  input wire logic slow_clock_input_pin_i,
  output logic slow_clk_o,
  output logic slow_tick_o,
  output logic slow_functions_en_o,
  // Power recovery
  input wire logic kbd_power_key_i,
  input wire logic power_button_i,
  output logic power_restore_o,
  // Domain enables
  output logic vcc_logic_en_o,
  output logic standby_blocks_en_o,
  output logic wake_init_o
);
  // --------
  // Main supply synchronizer
  // --------
  logic vcc_meta; // First stage, read only by the second.
  logic vcc_ok; // Synchronized main supply presence.

  // Two stages keep a slow rail edge from gating pins twice in a cycle.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      vcc_meta <= 1'b0;
      vcc_ok <= 1'b0;
    end else if (ce_i) begin
      vcc_meta <= vcc_present_i;
      vcc_ok <= vcc_meta;
    end
  end

  // --------
  // Standby reset fan-out
  // --------
  logic init_pulse; // High during reset and one cycle after.
  logic standby_en; // Standby blocks run from reset onward.

  // Downstream infrared and wake blocks see a clean init window.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      init_pulse <= 1'b1;
      standby_en <= 1'b0;
    end else if (ce_i) begin
      init_pulse <= 1'b0;
      standby_en <= 1'b1;
    end
  end

  assign wake_init_o = init_pulse;
  assign standby_blocks_en_o = standby_en;
  assign vcc_logic_en_o = vcc_ok;

  // --------
  // Registers
  // --------
  logic [7:0] bat_regs [BAT_REG_COUNT]; // Battery-backed storage.
  logic [7:0] slow_status; // Slow clock status register.
  logic [BAT_REG_COUNT-1:0] bat_hit; // Address decode per register.
  logic prev_capture; // Hardware update of the previous state.
  logic prev_value; // Value captured into the previous state.
  logic slow_absent; // Clock-absent flag.

  assign slow_absent = slow_status[BIT_CLK_ABSENT];

  // The battery bank ignores the standby reset; only the battery
  // power-on reset clears it, so a standby loss keeps its contents.
  for (genvar r = 0; r < BAT_REG_COUNT; r++) begin : g_bat
    assign bat_hit[r] = (reg_addr_i == BAT_OFFSETS[r]);
    always_ff @(posedge ref_clk_i) begin
      if (bat_por_i) begin
        bat_regs[r] <= BAT_REG_RESET;
      end else if (ce_i) begin
        if (r == IDX_SUPPLY_PREV && prev_capture) begin
          // A hardware capture wins over a software write.
          bat_regs[r][BIT_PREV_ON] <= prev_value;
        end else if (reg_wr_i && bat_hit[r]) begin
          bat_regs[r] <= reg_wdata_i;
        end
      end
    end
  end

  // The status register lives on the standby rail and clears on its reset.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      slow_status <= SLOW_STATUS_RESET;
    end else if (ce_i) begin
      if (reg_wr_i && reg_addr_i == OFS_SLOW_CLK_STATUS) begin
        // Only the flag is writable; upper bits read as zero.
        slow_status[BIT_CLK_ABSENT] <= reg_wdata_i[BIT_CLK_ABSENT];
      end
    end
  end

  // Read data is registered one cycle after the read strobe.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      reg_rdata_o <= READ_UNMAPPED;
    end else if (ce_i && reg_rd_i) begin
      reg_rdata_o <= READ_UNMAPPED;
      if (reg_addr_i == OFS_SLOW_CLK_STATUS) begin
        reg_rdata_o <= slow_status;
      end
      for (int r = 0; r < BAT_REG_COUNT; r++) begin
        if (bat_hit[r]) begin
          reg_rdata_o <= bat_regs[r];
        end
      end
    end
  end

  // --------
  // Slow clock selection
  // --------
  slow_clk_if sc ();

  assign sc.sel_internal = slow_absent;
  assign sc.ext_level = slow_clock_input_pin_i;

  slow_clock_select #(
    .HALF_CYCLES(HALF_CYCLES)
  ) u_select (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .sc(sc)
  );

  // Without an external clock the derived source stands for the
  // reference oscillator, which is gone under standby power alone.
  assign slow_functions_en_o = standby_en & (vcc_ok | ~sc.active_internal);
  assign slow_clk_o = sc.out_level;
  assign slow_tick_o = sc.tick & slow_functions_en_o;

  // --------
  // Wake pin gating
  // --------
  logic [WAKE_PINS-1:0] eff_alt; // Function after supply gating.
  logic [WAKE_PINS-1:0] eff_inv; // Inversion after supply gating.
  logic [WAKE_PINS-1:0] may_drive; // Pin may drive in this supply state.
  logic [WAKE_PINS-1:0] level; // Polarity-corrected pin level.
  logic [WAKE_PINS-1:0] level_q; // Level one cycle ago.
  logic [WAKE_PINS-1:0] wake_status; // Sticky wake status.

  for (genvar p = 0; p < WAKE_PINS; p++) begin : g_pin
    // The two mouse-side pins fall back to plain inputs without main supply.
    if (p == PIN_MOUSE_DATA || p == PIN_SECOND_REVERT) begin : g_rev
      assign eff_alt[p] = wake_pin_alt_i[p] & vcc_ok;
      assign eff_inv[p] = wake_pin_invert_i[p] & vcc_ok;
    end else begin : g_keep
      assign eff_alt[p] = wake_pin_alt_i[p];
      assign eff_inv[p] = wake_pin_invert_i[p];
    end
    // LED pins sit on the standby rail; all others need main supply.
    if (p == PIN_LED_ONE || p == PIN_LED_TWO) begin : g_led
      assign may_drive[p] = 1'b1;
    end else begin : g_vcc
      assign may_drive[p] = vcc_ok;
    end
    assign level[p] = wake_pin_i[p] ^ eff_inv[p];

    // Output drive is registered so the pin never sees a decode glitch.
    always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
        wake_pin_o[p] <= 1'b0;
        wake_pin_oe_o[p] <= 1'b0;
      end else if (ce_i) begin
        wake_pin_o[p] <= eff_alt[p] ? wake_pin_alt_out_i[p] : wake_pin_gpio_out_i[p];
        wake_pin_oe_o[p] <= may_drive[p] &
          (eff_alt[p] ? wake_pin_alt_oe_i[p] : wake_pin_gpio_oe_i[p]);
      end
    end

    // A rising corrected level sets the sticky bit; set beats clear.
    always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
        level_q[p] <= 1'b0;
        wake_status[p] <= 1'b0;
      end else if (ce_i) begin
        level_q[p] <= level[p];
        if (level[p] && !level_q[p]) begin
          wake_status[p] <= 1'b1;
        end else if (wake_status_clear_i[p]) begin
          wake_status[p] <= 1'b0;
        end
      end
    end
  end

  // Pin readback for the general-purpose data register.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      wake_pin_data_o <= '0;
    end else if (ce_i) begin
      wake_pin_data_o <= level;
    end
  end

  assign wake_status_o = wake_status;

  // --------
  // Non-wake pins
  // --------
  // These pins have no standby input path, so nothing here feeds the
  // wake status; they are only driven while main supply is present.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      non_wake_pin_o <= '0;
      non_wake_pin_oe_o <= '0;
    end else if (ce_i) begin
      non_wake_pin_o <= non_wake_out_i;
      non_wake_pin_oe_o <= non_wake_oe_i & {NON_WAKE_PINS{vcc_ok}};
    end
  end

  // --------
  // Wake output
  // --------
  logic wake_any; // Any enabled event pending.

  // The output works with or without main supply; it is open drain.
  assign wake_any = (|(wake_status & wake_pin_enable_i)) | block_event_i;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      wake_event_out_oe_o <= 1'b0;
    end else if (ce_i) begin
      wake_event_out_oe_o <= wake_any;
    end
  end

  // The pin only ever pulls low.
  assign wake_event_out_n_o = 1'b0;

  // --------
  // Power recovery
  // --------
  recovery_state_t rec_state; // Recovery sequencer state.
  recovery_state_t next_rec_state; // Next sequencer state.
  logic rec_enable; // Software arms recovery.
  logic supply_on; // Software supply request.
  logic vcc_ok_q; // Supply presence one cycle ago.

  assign rec_enable = bat_regs[IDX_PWR_RECOVERY][BIT_RECOVERY_EN];
  assign supply_on = bat_regs[IDX_SUPPLY_ON][BIT_SUPPLY_ON];
  // On an unexpected loss the supply request is remembered.
  assign prev_capture = ce_i & vcc_ok_q & ~vcc_ok;
  assign prev_value = supply_on;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      vcc_ok_q <= 1'b0;
    end else if (ce_i) begin
      vcc_ok_q <= vcc_ok;
    end
  end

  // Restore after a loss waits for a slow tick; a key or button press restores at once from REC_IDLE.
  always_comb begin
    next_rec_state = rec_state;
    case (rec_state)
      REC_IDLE: begin
        if (vcc_ok) begin
          next_rec_state = REC_ON;
        end else if (kbd_power_key_i || power_button_i) begin
          next_rec_state = REC_RESTORE;
        end
      end
      REC_ON: begin
        if (!vcc_ok) begin
          next_rec_state = (rec_enable && supply_on) ? REC_LOST : REC_IDLE;
        end
      end
      REC_LOST: begin
        if (vcc_ok) begin
          next_rec_state = REC_ON;
        end else if (slow_tick_o) begin
          next_rec_state = REC_RESTORE;
        end
      end
      REC_RESTORE: begin
        next_rec_state = vcc_ok ? REC_ON : REC_IDLE;
      end
      default: begin
        next_rec_state = REC_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rec_state <= REC_IDLE;
      power_restore_o <= 1'b0;
    end else if (ce_i) begin
      rec_state <= next_rec_state;
      power_restore_o <= (next_rec_state == REC_RESTORE) && (rec_state != REC_RESTORE);
    end
  end
endmodule : standby_well_wake_control

// file: tb/standby_well_wake_control_monitor.sv
`timescale 1ns/100ps
// Watches the block's ports; all checks except the two wake init ones are skipped while standby reset is high.
module standby_well_wake_control_monitor
  import standby_well_pkg::*;
#(
  parameter int WAKE_PINS = WAKE_PIN_COUNT,
  parameter int NON_WAKE_PINS = NON_WAKE_COUNT
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Watched ports
  input wire logic vcc_present_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic [WAKE_PINS-1:0] wake_pin_enable_i,
  input wire logic [WAKE_PINS-1:0] wake_status_o,
  input wire logic [WAKE_PINS-1:0] wake_pin_oe_o,
  input wire logic [NON_WAKE_PINS-1:0] non_wake_pin_oe_o,
  input wire logic block_event_i,
  input wire logic wake_event_out_oe_o,
  input wire logic slow_clk_o,
  input wire logic slow_tick_o,
  input wire logic slow_functions_en_o,
  input wire logic power_restore_o,
  input wire logic standby_blocks_en_o,
  input wire logic wake_init_o,
  input wire logic vcc_logic_en_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  AST_INIT_HOLD: assert property (disable iff (1'b0) rst_i |=> wake_init_o)
    else $error("wake init low after reset cycle");
  AST_INIT_DROP: assert property (disable iff (1'b0) $fell(rst_i) |=> !wake_init_o)
    else $error("wake init still high");
  AST_STBY_EN: assert property (!rst_i [*2] |-> standby_blocks_en_o)
    else $error("standby blocks not enabled");
  AST_VCC_EN: assert property ($stable(vcc_present_i) [*4] |-> vcc_logic_en_o == vcc_present_i)
    else $error("main supply enable does not follow supply");
  // LED pins sit at the top of the vector, so all lower bits must float without main supply.
  AST_NOVCC_OE: assert property (!vcc_present_i [*4] |->
    wake_pin_oe_o[PIN_LED_ONE-1:0] == '0 && non_wake_pin_oe_o == '0)
    else $error("pin driven without main supply");
  AST_WAKE_OUT: assert property (|(wake_status_o & wake_pin_enable_i) |=> wake_event_out_oe_o)
    else $error("enabled event did not pull wake output");
  AST_WAKE_CAUSE: assert property ($rose(wake_event_out_oe_o) |->
    $past(|(wake_status_o & wake_pin_enable_i)) || $past(block_event_i) || $past(block_event_i, 2))
    else $error("wake output without cause");
  AST_RD_FLAG: assert property (reg_rd_i && reg_addr_i == OFS_SLOW_CLK_STATUS |=>
    reg_rdata_o[7:1] == 7'h00)
    else $error("slow status upper bits not zero");
  AST_RESTORE: assert property (power_restore_o |=> !power_restore_o)
    else $error("restore pulse longer than one cycle");
  AST_NO_RUNT: assert property ($changed(slow_clk_o) |=> $stable(slow_clk_o))
    else $error("runt pulse on slow clock");
  AST_TICK_GATED: assert property (slow_tick_o |->
    (slow_functions_en_o && !slow_clk_o) ##1 slow_clk_o)
    else $error("slow tick while slow functions off");
  COV_WAKE: cover property ($rose(wake_event_out_oe_o));
  COV_RESTORE: cover property (power_restore_o);
  COV_SLOW_NOVCC: cover property ($changed(slow_clk_o) && !vcc_logic_en_o);
endmodule : standby_well_wake_control_monitor

// file: tb/wake_chipset_model.sv
`timescale 1ns/100ps
// Chipset end of the open-drain wake line; a board pull-up holds it high when released.
module wake_chipset_model (
  // Wake pin as driven by the block
  input wire logic wake_n_i,
  input wire logic wake_oe_i,
  // Resolved line and count of wake requests
  output logic line_o,
  output int wakes_o
);
  assign line_o = wake_oe_i ? wake_n_i : 1'b1;
  initial wakes_o = 0;
  // Each falling edge is one power management request.
  always @(negedge line_o) begin
    wakes_o = wakes_o + 1;
  end
endmodule : wake_chipset_model

// file: tb/standby_well_wake_control_tb.sv
`timescale 1ns/100ps
module standby_well_wake_control_tb;
  import standby_well_pkg::*;
  localparam int W = WAKE_PIN_COUNT;
  localparam int N = NON_WAKE_COUNT;
  // Stimulus, changed only by non-blocking assignment on the rising edge.
  logic ref_clk_i = 1'b0, rst_i = 1'b1, bat_por_i = 1'b1, vcc_present_i = 1'b1, ext_run = 1'b1;
  logic reg_wr_i = 1'b0, reg_rd_i = 1'b0, block_event_i = 1'b0, slow_clock_input_pin_i = 1'b0;
  logic kbd_power_key_i = 1'b0, power_button_i = 1'b0, rd_d = 1'b0, sc_d = 1'b0, ce_i = 1'b1;
  logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00;
  logic [W-1:0] ext_lvl = '0, wake_pin_alt_i = '0, wake_pin_invert_i = '0, wake_pin_enable_i = '0;
  logic [W-1:0] wake_pin_gpio_out_i = '0, wake_pin_gpio_oe_i = '0, wake_pin_alt_out_i = '0;
  logic [W-1:0] wake_pin_alt_oe_i = '0, wake_status_clear_i = '0;
  logic [N-1:0] non_wake_out_i = '0, non_wake_oe_i = '0;
  // Outputs and resolved pin levels.
  logic [7:0] reg_rdata_o;
  logic [W-1:0] wake_pin_i, wake_pin_o, wake_pin_oe_o, wake_pin_data_o, wake_status_o;
  logic [N-1:0] non_wake_pin_o, non_wake_pin_oe_o;
  logic wake_event_out_n_o, wake_event_out_oe_o, slow_clk_o, slow_tick_o, slow_functions_en_o;
  logic power_restore_o, vcc_logic_en_o, standby_blocks_en_o, wake_init_o, wake_line;
  int wakes, n_fail = 0, checks_done = 0, n_restore = 0, n_tog = 0, ph = 0;
  int seed = 32'hC501C257;
  logic [7:0] exp_q[$];
  logic [7:0] keep [BAT_REG_COUNT];
  // A pin follows the block while it drives, else the board level.
  assign wake_pin_i = (wake_pin_oe_o & wake_pin_o) | (~wake_pin_oe_o & ext_lvl);
  standby_well_wake_control #(.HALF_CYCLES(4)) dut (
    .ref_clk_i, .rst_i, .bat_por_i, .ce_i, .vcc_present_i, .reg_addr_i, .reg_wdata_i,
    .reg_wr_i, .reg_rd_i, .reg_rdata_o, .wake_pin_i, .wake_pin_alt_i, .wake_pin_invert_i,
    .wake_pin_gpio_out_i, .wake_pin_gpio_oe_i, .wake_pin_alt_out_i, .wake_pin_alt_oe_i,
    .wake_pin_enable_i, .wake_status_clear_i, .wake_pin_o, .wake_pin_oe_o, .wake_pin_data_o,
    .wake_status_o, .non_wake_out_i, .non_wake_oe_i, .non_wake_pin_o, .non_wake_pin_oe_o,
    .block_event_i, .wake_event_out_n_o, .wake_event_out_oe_o, .slow_clock_input_pin_i,
    .slow_clk_o, .slow_tick_o, .slow_functions_en_o, .kbd_power_key_i, .power_button_i,
    .power_restore_o, .vcc_logic_en_o, .standby_blocks_en_o, .wake_init_o);
  wake_chipset_model chipset (.wake_n_i(wake_event_out_n_o), .wake_oe_i(wake_event_out_oe_o),
    .line_o(wake_line), .wakes_o(wakes));
  always #5 ref_clk_i = ~ref_clk_i;
  // Board slow clock: twelve core cycles a period; a missing clock is a grounded pin.
  always @(posedge ref_clk_i) begin
    ph <= (ph + 1) % 12;
    slow_clock_input_pin_i <= ext_run && ph < 6;
  end
  // Result watcher: read data is due one cycle after the read strobe.
  always @(posedge ref_clk_i) begin
    rd_d <= reg_rd_i;
    sc_d <= slow_clk_o;
    if (power_restore_o === 1'b1) n_restore++;
    if (slow_clk_o !== sc_d) n_tog++;
    if (rd_d) chk("reg_rdata_o", exp_q.pop_front(), reg_rdata_o);
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    checks_done++;
    if (s !== e) begin
      n_fail++;
      $display("[ERR] %s expected %0h seen %0h", nm, e, s);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask : step
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    step(1);
    reg_wr_i <= 1'b0;
    step(1);
  endtask : wreg
  task automatic rreg(input logic [7:0] a, input logic [7:0] e);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    exp_q.push_back(e);
    step(1);
    reg_rd_i <= 1'b0;
    step(1);
  endtask : rreg
  task automatic end_of_test();
    if (n_fail == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_of_test
  initial begin
    #300000;
    n_fail++;
    end_of_test();
  end
  initial begin
    step(8);
    rst_i <= 1'b0;
    bat_por_i <= 1'b0;
    step(1);
    // Reset contents, an unmapped offset, then a standby reset over random contents.
    for (int i = 0; i < BAT_REG_COUNT; i++) rreg(BAT_OFFSETS[i], BAT_REG_RESET);
    rreg(OFS_SLOW_CLK_STATUS, SLOW_STATUS_RESET);
    rreg(8'h20, READ_UNMAPPED);
    for (int i = 0; i < BAT_REG_COUNT; i++) begin
      keep[i] = 8'($random(seed));
      wreg(BAT_OFFSETS[i], keep[i]);
    end
    wreg(OFS_SLOW_CLK_STATUS, 8'hFF);
    rreg(OFS_SLOW_CLK_STATUS, 8'h01);
    rst_i <= 1'b1;
    step(2);
    rst_i <= 1'b0;
    step(1);
    for (int i = 0; i < BAT_REG_COUNT; i++) rreg(BAT_OFFSETS[i], keep[i]);
    rreg(OFS_SLOW_CLK_STATUS, 8'h00);
    // Enabled and disabled wake pins, then another block's event.
    wake_pin_enable_i <= 15'h0001;
    ext_lvl <= 15'h0021;
    step(5);
    chk("wake_status_o", 15'h0021, wake_status_o);
    chk("wake_line", 0, wake_line);
    wake_status_clear_i <= '1;
    step(1);
    wake_status_clear_i <= '0;
    step(4);
    chk("wake_line", 1, wake_line);
    ext_lvl[6] <= 1'b1;
    step(5);
    chk("wake_status_o", 15'h0040, wake_status_o);
    chk("wake_line", 1, wake_line);
    block_event_i <= 1'b1;
    step(4);
    chk("wake_line", 0, wake_line);
    chk("wakes", 2, wakes);
    block_event_i <= 1'b0;
    // Main supply lost with recovery armed and every pin asked to drive.
    wreg(OFS_PWR_RECOVERY, 8'h01);
    wreg(OFS_SUPPLY_ON, 8'h01);
    wreg(OFS_SUPPLY_PREV, 8'h00);
    ext_lvl <= '0;
    wake_pin_alt_i <= '1;
    wake_pin_invert_i <= 15'h0018;
    wake_pin_gpio_out_i <= W'($random(seed));
    wake_pin_gpio_oe_i <= '1;
    wake_pin_alt_out_i <= '1;
    wake_pin_alt_oe_i <= '1;
    non_wake_out_i <= N'($random(seed));
    non_wake_oe_i <= '1;
    step(4);
    vcc_present_i <= 1'b0;
    step(8);
    chk("wake_pin_oe_o", 15'h6000, wake_pin_oe_o);
    chk("non_wake_pin_oe_o", 0, non_wake_pin_oe_o);
    chk("wake_pin_data_o", 15'h6000, wake_pin_data_o);
    chk("wake_pin_o", wake_pin_gpio_out_i[4:3], wake_pin_o[4:3]);
    chk("non_wake_pin_o", non_wake_out_i, non_wake_pin_o);
    wake_status_clear_i <= '1;
    step(1);
    wake_status_clear_i <= '0;
    wake_pin_enable_i <= 15'h0008;
    ext_lvl[3] <= 1'b1;
    step(5);
    chk("wake_status_o", 15'h0008, wake_status_o);
    step(30);
    chk("power_restore_o pulses", 1, n_restore);
    power_button_i <= 1'b1;
    step(1);
    power_button_i <= 1'b0;
    step(3);
    chk("power_restore_o pulses", 2, n_restore);
    rreg(OFS_SUPPLY_PREV, 8'h01);
    chk("slow_functions_en_o", 1, slow_functions_en_o);
    // Slow clock source: external running, external grounded, then derived.
    n_tog = 0;
    step(48);
    chk("slow clock moving", 1, n_tog > 5);
    ext_run <= 1'b0;
    step(20);
    n_tog = 0;
    step(40);
    chk("slow clock toggles", 0, n_tog);
    wreg(OFS_SLOW_CLK_STATUS, 8'h01);
    step(10);
    chk("slow_functions_en_o", 0, slow_functions_en_o);
    vcc_present_i <= 1'b1;
    step(10);
    chk("slow_functions_en_o", 1, slow_functions_en_o);
    n_tog = 0;
    step(40);
    chk("slow clock moving", 1, n_tog > 5);
    ce_i <= 1'b0;
    step(2);
    n_tog = 0;
    step(10);
    chk("frozen slow clock", 0, n_tog);
    ce_i <= 1'b1;
    chk("reads left", 0, exp_q.size());
    end_of_test();
  end
endmodule : standby_well_wake_control_tb
bind standby_well_wake_control standby_well_wake_control_monitor #(
  .WAKE_PINS(WAKE_PINS), .NON_WAKE_PINS(NON_WAKE_PINS)) mon (
  .ref_clk_i, .rst_i, .vcc_present_i, .reg_addr_i, .reg_rd_i, .reg_rdata_o, .wake_pin_enable_i,
  .wake_status_o, .wake_pin_oe_o, .non_wake_pin_oe_o, .block_event_i, .wake_event_out_oe_o,
  .slow_clk_o, .slow_tick_o, .slow_functions_en_o, .power_restore_o, .standby_blocks_en_o,
  .wake_init_o, .vcc_logic_en_o);
